// [core/sme_exec.sv]
// Overview of operation
// [RL1] Right shift: bits move down, zero enters MSB, old LSB to carry.
// [RL2] Right shift result goes to W when dest is 0, file when 1.
// [RL3] File move copies file to W, or rewrites it unchanged when dest is 1.
// [RL4] File move always updates zero flag, so self-move tests for zero.
// [RL5] Indirect load puts memory at pointer-selected address into W.
// [RL6] Update code: 00 preinc, 01 predec, 10 postinc, 11 postdec.
// [RL7] Address: pointer+1, pointer-1, pointer+offset, or plain pointer.
// [RL8] Afterwards pointer is +1 for increments, -1 decrements, same relative.
// [RL9] Relative mode adds signed offset from -32 to 31 to pointer.
// [RL10] Indirect window has no storage; it reaches the pointed location.
// [RL11] Pointers are 16 bits and wrap at both ends.
// [RL12] Shift and load set Z from result; move and load keep carry.
// [RL13] Indirect load picks one of two pointers by a one-bit index.
module sme_exec (
    // Clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_i,
    // Instruction issue from decoder
    input  wire logic                       ins_valid_i,
    input  wire sme_pkg::sme_op_t           ins_op_i,
    input  wire logic [sme_pkg::SME_FW-1:0] ins_faddr_i,
    input  wire logic                       ins_dest_i,
    input  wire logic                       ins_ptr_sel_i,
    input  wire sme_pkg::sme_upd_t          ins_upd_i,
    input  wire logic                       ins_rel_i,
    input  wire logic [sme_pkg::SME_OFW-1:0] ins_offset_i,
    output logic                            ins_ready_o,
    output logic                            ins_done_o,
    // Core state
    output logic [sme_pkg::SME_DW-1:0]      w_o,
    output logic                            carry_o,
    output logic                            zero_o,
    // Avalon-MM slave
    input  wire logic [sme_pkg::SME_BA-1:0] avs_address_i,
    input  wire logic                       avs_read_i,
    input  wire logic                       avs_write_i,
    input  wire logic [31:0]                avs_writedata_i,
    output logic      [31:0]                avs_readdata_o,
    output logic                            avs_waitrequest_o
);
    import sme_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [SME_AW-1:0] ptr_of(
        input sme_st_t s,
        input logic    sel
    );
        return sel ? s.ptr1 : s.ptr0;  // [RL13]
    endfunction : ptr_of

    function automatic logic [SME_AW-1:0] eff_addr(
        input logic [SME_AW-1:0]  ptr,
        input sme_upd_t           upd,
        input logic               rel,
        input logic [SME_OFW-1:0] off
    );
        logic [SME_AW-1:0] sext;
        sext = {{(SME_AW-SME_OFW){off[SME_OFW-1]}}, off};  // [RL9]
        if (rel) begin
            return ptr + sext;  // [RL7] [RL11]
        end
        unique case (upd)  // [RL6]
            SME_UPD_PRE_INC: return ptr + SME_PTR_STEP;  // [RL7]
            SME_UPD_PRE_DEC: return ptr - SME_PTR_STEP;  // [RL7]
            SME_UPD_POST_INC,
            SME_UPD_POST_DEC: return ptr;  // [RL7]
        endcase
    endfunction : eff_addr

    function automatic logic [31:0] reg_read(
        input sme_st_t           s,
        input logic [SME_BA-1:0] a
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            SME_REG_W:     d[SME_DW-1:0] = s.w;
            SME_REG_STAT: begin
                d[SME_ST_C]    = s.c;
                d[SME_ST_Z]    = s.z;
                d[SME_ST_BUSY] = (s.state != SME_S_IDLE);
            end
            SME_REG_PTR0:  d[SME_AW-1:0] = s.ptr0;
            SME_REG_PTR1:  d[SME_AW-1:0] = s.ptr1;
            SME_REG_MADDR: d[SME_AW-1:0] = s.maddr;
            default:       d = 32'h0000_0000;
        endcase
        return d;
    endfunction : reg_read

    // ==========================================================
    // State
    sme_st_t           st_r;
    sme_st_t           st_nxt;
    logic [SME_AW-1:0] mem_addr;
    logic              mem_we;
    logic [SME_DW-1:0] mem_wdata;
    logic [SME_DW-1:0] mem_rdata;
    logic [SME_DW-1:0] res;
    logic [SME_AW-1:0] ptr_cur;
    logic [SME_AW-1:0] ptr_new;
    logic [SME_AW-1:0] fa_ext;

    assign ptr_cur = ptr_of(st_r, ins_ptr_sel_i);
    assign fa_ext  = {{(SME_AW-SME_FW){1'b0}}, st_r.faddr};

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        st_nxt.wreq = 1'b1;
        mem_addr    = st_r.addr;
        mem_we      = 1'b0;
        mem_wdata   = st_r.w;
        res         = mem_rdata;
        ptr_new     = ptr_of(st_r, st_r.psel);
        unique case (st_r.state)
            SME_S_IDLE: begin
                if (ins_valid_i && st_r.ready) begin
                    st_nxt.op    = ins_op_i;
                    st_nxt.dest  = ins_dest_i;
                    st_nxt.psel  = ins_ptr_sel_i;
                    st_nxt.upd   = ins_upd_i;
                    st_nxt.rel   = ins_rel_i;
                    st_nxt.faddr = ins_faddr_i;
                    st_nxt.state = SME_S_FETCH;
                    // Window address is the pointed location
                    if (ins_op_i == SME_OP_ILOAD) begin
                        st_nxt.addr = eff_addr(ptr_cur, ins_upd_i,
                                               ins_rel_i,
                                               ins_offset_i);  // [RL10]
                    end else begin
                        st_nxt.addr = {{(SME_AW-SME_FW){1'b0}},
                                       ins_faddr_i};
                    end
                end else if ((avs_read_i || avs_write_i) && st_r.wreq) begin
                    if (avs_read_i && avs_address_i == SME_REG_MDATA) begin
                        st_nxt.state = SME_S_BUSRD;
                        st_nxt.wreq  = 1'b1;
                    end else begin
                        st_nxt.rdata = reg_read(st_r, avs_address_i);
                        st_nxt.wreq  = 1'b0;
                    end
                end else if (avs_write_i && !st_r.wreq) begin
                    // Writes commit on the edge that completes the transfer
                    unique case (avs_address_i)
                        SME_REG_W: begin
                            st_nxt.w = avs_writedata_i[SME_DW-1:0];
                        end
                        SME_REG_STAT: begin
                            st_nxt.c = avs_writedata_i[SME_ST_C];
                            st_nxt.z = avs_writedata_i[SME_ST_Z];
                        end
                        SME_REG_PTR0: begin
                            st_nxt.ptr0 = avs_writedata_i[SME_AW-1:0];
                        end
                        SME_REG_PTR1: begin
                            st_nxt.ptr1 = avs_writedata_i[SME_AW-1:0];
                        end
                        SME_REG_MADDR: begin
                            st_nxt.maddr = avs_writedata_i[SME_AW-1:0];
                        end
                        SME_REG_MDATA: begin
                            mem_addr  = st_r.maddr;
                            mem_we    = 1'b1;
                            mem_wdata = avs_writedata_i[SME_DW-1:0];
                        end
                        default: begin
                            mem_we = 1'b0;
                        end
                    endcase
                end
            end
            SME_S_FETCH: begin
                st_nxt.state = SME_S_EXEC;
            end
            SME_S_EXEC: begin
                st_nxt.state = SME_S_IDLE;
                st_nxt.done  = 1'b1;
                unique case (st_r.op)
                    SME_OP_SHR: begin
                        res      = {1'b0, mem_rdata[SME_DW-1:1]};  // [RL1]
                        st_nxt.c = mem_rdata[0];  // [RL1]
                        st_nxt.z = (res == 8'h00);  // [RL12]
                        if (st_r.dest) begin
                            mem_addr  = fa_ext;  // [RL2]
                            mem_we    = 1'b1;
                            mem_wdata = res;
                        end else begin
                            st_nxt.w = res;  // [RL2]
                        end
                    end
                    SME_OP_MOVE: begin
                        st_nxt.z = (mem_rdata == 8'h00);  // [RL4]
                        if (st_r.dest) begin
                            mem_addr  = fa_ext;  // [RL3]
                            mem_we    = 1'b1;
                            mem_wdata = mem_rdata;
                        end else begin
                            st_nxt.w = mem_rdata;  // [RL3]
                        end
                    end
                    SME_OP_ILOAD: begin
                        st_nxt.w = mem_rdata;  // [RL5]
                        st_nxt.z = (mem_rdata == 8'h00);  // [RL12]
                        if (!st_r.rel) begin
                            // Both increment codes have a clear bit 0
                            if (st_r.upd[0]) begin
                                ptr_new = ptr_new - SME_PTR_STEP;  // [RL8]
                            end else begin
                                ptr_new = ptr_new + SME_PTR_STEP;  // [RL8]
                            end
                        end
                        if (st_r.psel) begin
                            st_nxt.ptr1 = ptr_new;  // [RL11]
                        end else begin
                            st_nxt.ptr0 = ptr_new;  // [RL11]
                        end
                    end
                    SME_OP_NONE: begin
                        st_nxt.done = 1'b1;
                    end
                endcase
            end
            SME_S_BUSRD: begin
                mem_addr     = st_r.maddr;
                st_nxt.state = SME_S_BUSDONE;
            end
            SME_S_BUSDONE: begin
                st_nxt.rdata = {{(32-SME_DW){1'b0}}, mem_rdata};
                st_nxt.wreq  = 1'b0;
                st_nxt.state = SME_S_IDLE;
            end
            default: begin
                st_nxt.state = SME_S_IDLE;
            end
        endcase
        // No issue on a bus completion edge, so registers never race
        st_nxt.ready = (st_nxt.state == SME_S_IDLE) && st_nxt.wreq;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_r <= SME_ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Data memory, also the file register space
    sme_mem #(
        .AW (SME_AW),
        .DW (SME_DW)
    ) u_mem (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .addr_i    (mem_addr),
        .we_i      (mem_we),
        .wdata_i   (mem_wdata),
        .rdata_o   (mem_rdata)
    );

    // ==========================================================
    // Outputs
    assign ins_ready_o       = st_r.ready;
    assign ins_done_o        = st_r.done;
    assign w_o               = st_r.w;
    assign carry_o           = st_r.c;
    assign zero_o            = st_r.z;
    assign avs_readdata_o    = st_r.rdata;
    assign avs_waitrequest_o = st_r.wreq;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    logic exec_shr;
    logic exec_mov;
    logic exec_ild;
    assign exec_shr = (st_r.state == SME_S_EXEC) && (st_r.op == SME_OP_SHR);
    assign exec_mov = (st_r.state == SME_S_EXEC) && (st_r.op == SME_OP_MOVE);
    assign exec_ild = (st_r.state == SME_S_EXEC) && (st_r.op == SME_OP_ILOAD);

    sequence s_issue_ild;
        ins_valid_i && ins_ready_o && (ins_op_i == SME_OP_ILOAD);
    endsequence

    sequence s_ild_step;
        (st_r.state == SME_S_FETCH) ##1 exec_ild;
    endsequence

    a_shift_value: assert property (  // [RL1]
        exec_shr && !st_r.dest |=> (w_o == ($past(mem_rdata) >> 1))
            && (carry_o == $past(mem_rdata[0])))
        else $error("shift result or carry wrong");

    a_shift_dest: assert property (  // [RL2]
        exec_shr && st_r.dest |-> mem_we && (mem_addr == fa_ext)
            && (mem_wdata == (mem_rdata >> 1)) ##1 $stable(w_o))
        else $error("shift writeback wrong");

    a_move_copy: assert property (  // [RL3]
        exec_mov |=> (st_r.dest ? $stable(w_o) : (w_o == $past(mem_rdata))))
        else $error("file move destination wrong");

    a_move_zero: assert property (  // [RL4]
        exec_mov |=> (zero_o == ($past(mem_rdata) == 8'h00)))
        else $error("file move zero flag wrong");

    a_iload_path: assert property (  // [RL5]
        s_issue_ild ##1 s_ild_step |=> (w_o == $past(mem_rdata))
            && ins_done_o)
        else $error("indirect load value wrong");

    a_pre_inc_addr: assert property (  // [RL7]
        s_issue_ild and (!ins_rel_i && ins_upd_i == SME_UPD_PRE_INC)
        |=> (mem_addr == $past(ptr_cur) + SME_PTR_STEP))
        else $error("preincrement address wrong");

    a_rel_addr: assert property (  // [RL9]
        s_issue_ild and ins_rel_i |=> (mem_addr == $past(ptr_cur)
            + {{(SME_AW-SME_OFW){$past(ins_offset_i[SME_OFW-1])}},
               $past(ins_offset_i)}))
        else $error("relative address wrong");

    a_ptr_after: assert property (  // [RL8]
        exec_ild |=> (ptr_of(st_r, st_r.psel) == ($past(st_r.rel)
            ? $past(ptr_of(st_r, st_r.psel))
            : ($past(st_r.upd[0]) ? $past(ptr_of(st_r, st_r.psel)) - 16'h1
                                 : $past(ptr_of(st_r, st_r.psel)) + 16'h1))))
        else $error("pointer update wrong");

    a_carry_kept: assert property (  // [RL12]
        exec_mov || exec_ild |=> $stable(carry_o))
        else $error("carry changed by move or load");

    a_bus_answer: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o
            && (st_r.state == SME_S_IDLE) && !ins_valid_i
        |-> ##[1:3] !avs_waitrequest_o)
        else $error("bus not answered");

endmodule : sme_exec

// [core/sme_pkg.sv]
package sme_pkg;

    // ==========================================================
    // Widths
    localparam int SME_AW  = 16;
    localparam int SME_DW  = 8;
    localparam int SME_FW  = 7;
    localparam int SME_OFW = 6;
    localparam int SME_BA  = 5;

    // ==========================================================
    // Register map, byte addresses on a 32-bit bus
    localparam logic [SME_BA-1:0] SME_REG_W     = 5'h00;
    localparam logic [SME_BA-1:0] SME_REG_STAT  = 5'h04;
    localparam logic [SME_BA-1:0] SME_REG_PTR0  = 5'h08;
    localparam logic [SME_BA-1:0] SME_REG_PTR1  = 5'h0c;
    localparam logic [SME_BA-1:0] SME_REG_MADDR = 5'h10;
    localparam logic [SME_BA-1:0] SME_REG_MDATA = 5'h14;

    // Status field positions
    localparam int SME_ST_C    = 0;
    localparam int SME_ST_Z    = 1;
    localparam int SME_ST_BUSY = 8;

    // Values after reset
    localparam logic [SME_DW-1:0] SME_W_RST   = 8'h00;
    localparam logic [SME_AW-1:0] SME_PTR_RST = 16'h0000;
    localparam logic [31:0]       SME_RD_RST  = 32'h0000_0000;

    // Pointer step
    localparam logic [SME_AW-1:0] SME_PTR_STEP = 16'h0001;

    // ==========================================================
    // Enumerations
    typedef enum logic [1:0] {
        SME_OP_SHR,
        SME_OP_MOVE,
        SME_OP_ILOAD,
        SME_OP_NONE
    } sme_op_t;

    typedef enum logic [1:0] {
        SME_UPD_PRE_INC,
        SME_UPD_PRE_DEC,
        SME_UPD_POST_INC,
        SME_UPD_POST_DEC
    } sme_upd_t;

    typedef enum logic [2:0] {
        SME_S_IDLE,
        SME_S_FETCH,
        SME_S_EXEC,
        SME_S_BUSRD,
        SME_S_BUSDONE
    } sme_state_t;

    // ==========================================================
    // Whole state of the execution block
    typedef struct packed {
        sme_state_t        state;
        sme_op_t           op;
        logic              dest;
        logic              psel;
        sme_upd_t          upd;
        logic              rel;
        logic [SME_FW-1:0] faddr;
        logic [SME_AW-1:0] addr;
        logic [SME_DW-1:0] w;
        logic              c;
        logic              z;
        logic [SME_AW-1:0] ptr0;
        logic [SME_AW-1:0] ptr1;
        logic [SME_AW-1:0] maddr;
        logic [31:0]       rdata;
        logic              wreq;
        logic              ready;
        logic              done;
    } sme_st_t;

    localparam sme_st_t SME_ST_RST = '{
        state: SME_S_IDLE, op: SME_OP_NONE, dest: 1'b0, psel: 1'b0,
        upd: SME_UPD_PRE_INC, rel: 1'b0, faddr: 7'h00, addr: 16'h0000,
        w: SME_W_RST, c: 1'b0, z: 1'b0, ptr0: SME_PTR_RST,
        ptr1: SME_PTR_RST, maddr: 16'h0000, rdata: SME_RD_RST,
        wreq: 1'b1, ready: 1'b1, done: 1'b0};

endpackage : sme_pkg

// [core/sme_mem.sv]
module sme_mem #(
    parameter int AW = 16,
    parameter int DW = 8
) (
    // Clock and reset
    input  wire logic          clk_sys_i,
    input  wire logic          rst_i,
    // Single port
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          we_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem_r [0:(2**AW)-1];

    // Array has no reset: only the read register is cleared
    always_ff @(posedge clk_sys_i) begin
        if (we_i) begin
            mem_r[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem_r[addr_i];
        end
    end

endmodule : sme_mem

// [tb/sme_exec_tb.sv]
module sme_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sme_pkg::*;

    // ==========================================================
    // Stimulus and observation
    logic                 clk_sys_i       = 1'b0;
    logic                 rst_i           = 1'b1;
    logic                 ins_valid_i     = 1'b0;
    sme_op_t              ins_op_i        = SME_OP_NONE;
    logic [SME_FW-1:0]    ins_faddr_i     = 7'h00;
    logic                 ins_dest_i      = 1'b0;
    logic                 ins_ptr_sel_i   = 1'b0;
    sme_upd_t             ins_upd_i       = SME_UPD_PRE_INC;
    logic                 ins_rel_i       = 1'b0;
    logic [SME_OFW-1:0]   ins_offset_i    = 6'h00;
    logic                 ins_ready_o;
    logic                 ins_done_o;
    logic [SME_DW-1:0]    w_o;
    logic                 carry_o;
    logic                 zero_o;
    logic [SME_BA-1:0]    avs_address_i   = 5'h00;
    logic                 avs_read_i      = 1'b0;
    logic                 avs_write_i     = 1'b0;
    logic [31:0]          avs_writedata_i = 32'h0000_0000;
    logic [31:0]          avs_readdata_o;
    logic                 avs_waitrequest_o;
    int                   n_errors        = 0;
    int                   total_checks    = 0;
    int                   seed            = 32'h0c85;

    always #5 clk_sys_i = ~clk_sys_i;

    sme_exec sme_exec_i (
        .clk_sys_i         (clk_sys_i),
        .rst_i             (rst_i),
        .ins_valid_i       (ins_valid_i),
        .ins_op_i          (ins_op_i),
        .ins_faddr_i       (ins_faddr_i),
        .ins_dest_i        (ins_dest_i),
        .ins_ptr_sel_i     (ins_ptr_sel_i),
        .ins_upd_i         (ins_upd_i),
        .ins_rel_i         (ins_rel_i),
        .ins_offset_i      (ins_offset_i),
        .ins_ready_o       (ins_ready_o),
        .ins_done_o        (ins_done_o),
        .w_o               (w_o),
        .carry_o           (carry_o),
        .zero_o            (zero_o),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o)
    );

    // ==========================================================
    // Verdict and comparison
    task automatic end_sim();
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic hung(input string what);
        n_errors++;
        $display("unexpected %s expected answer seen none", what);
        end_sim();
    endtask : hung

    // ==========================================================
    // Avalon-MM master: hold until waitrequest is sampled low
    task automatic av_xfer(input logic wr_en, input logic [SME_BA-1:0] a,
                           input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_sys_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_read_i      <= ~wr_en;
        avs_write_i     <= wr_en;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys_i);
            if (avs_waitrequest_o === 1'b0)
                break;
        end
        if (n == 50)
            hung("waitrequest");
        q = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : av_xfer

    task automatic wr(input logic [SME_BA-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        av_xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [SME_BA-1:0] a, output logic [31:0] q);
        av_xfer(1'b0, a, 32'h0000_0000, q);
    endtask : rd

    task automatic mem_put(input logic [15:0] a, input logic [7:0] v);
        wr(SME_REG_MADDR, {16'h0000, a});
        wr(SME_REG_MDATA, {24'h00_0000, v});
    endtask : mem_put

    task automatic mem_get(input logic [15:0] a, output logic [31:0] q);
        wr(SME_REG_MADDR, {16'h0000, a});
        rd(SME_REG_MDATA, q);
    endtask : mem_get

    // ==========================================================
    // Instruction issue, fixed three-cycle completion
    task automatic run_ins(input sme_op_t op, input logic [6:0] f,
                           input logic d, input logic ps,
                           input logic [1:0] u, input logic rl,
                           input logic [5:0] of);
        int n;
        @(posedge clk_sys_i);
        ins_valid_i   <= 1'b1;
        ins_op_i      <= op;
        ins_faddr_i   <= f;
        ins_dest_i    <= d;
        ins_ptr_sel_i <= ps;
        ins_upd_i     <= sme_upd_t'(u);
        ins_rel_i     <= rl;
        ins_offset_i  <= of;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys_i);
            if (ins_ready_o === 1'b1)
                break;
        end
        if (n == 50)
            hung("ready");
        ins_valid_i <= 1'b0;
        #1;
        check("ready busy", 32'(ins_ready_o), 32'h0);
        repeat (2) @(posedge clk_sys_i);
        #1;
        check("done", 32'(ins_done_o), 32'h1);
    endtask : run_ins

    // ==========================================================
    // Expected indirect address and pointer afterwards
    function automatic logic [15:0] ild_addr(input logic [15:0] p,
                                             input logic [1:0]  u,
                                             input logic        rl,
                                             input logic [5:0]  of);
        if (rl)
            return p + {{10{of[5]}}, of};
        return (u == 2'b00) ? p + 16'h0001 :
               (u == 2'b01) ? p - 16'h0001 : p;
    endfunction : ild_addr

    function automatic logic [15:0] ild_ptr(input logic [15:0] p,
                                            input logic [1:0]  u,
                                            input logic        rl);
        if (rl)
            return p;
        return u[0] ? p - 16'h0001 : p + 16'h0001;
    endfunction : ild_ptr

    // ==========================================================
    // Main sequence
    initial begin
        int          i;
        logic [31:0] q;
        logic [7:0]  v, w0, r;
        logic [6:0]  f;
        logic        d, c0, ps, rl, ec;
        logic [1:0]  u;
        logic [5:0]  of;
        logic [15:0] p, p2, ea, np;
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(SME_REG_W, q);
        check("w reset", q, 32'h0);
        rd(SME_REG_STAT, q);
        check("status reset", q, 32'h0);
        rd(SME_REG_PTR1, q);
        check("ptr1 reset", q, 32'h0);
        wr(5'h18, 32'hffff_ffff);
        rd(5'h18, q);
        check("unmapped", q, 32'h0);
        wr(SME_REG_W, 32'h1234_56a5);
        rd(SME_REG_W, q);
        check("w upper", q, 32'h0000_00a5);
        // Shift and move, first two values give carry-out and zero
        for (i = 0; i < 24; i++) begin
            f  = 7'($random(seed));
            v  = (i < 2) ? 8'(1 - i) : 8'($random(seed));
            d  = 1'($random(seed));
            w0 = 8'($random(seed));
            c0 = 1'($random(seed));
            mem_put({9'h000, f}, v);
            wr(SME_REG_W, {24'h00_0000, w0});
            wr(SME_REG_STAT, {31'h0, c0});
            run_ins(i[0] ? SME_OP_MOVE : SME_OP_SHR, f, d, 1'b0, 2'b00,
                    1'b0, 6'h00);
            r  = i[0] ? v : {1'b0, v[7:1]};
            ec = i[0] ? c0 : v[0];
            check("w", 32'(w_o), 32'(d ? w0 : r));
            check("carry", 32'(carry_o), 32'(ec));
            check("zero", 32'(zero_o), 32'(r == 8'h00));
            mem_get({9'h000, f}, q);
            check("file", q, 32'(d ? r : v));
        end
        // No-operation completes and leaves accumulator and carry alone
        run_ins(SME_OP_NONE, 7'h00, 1'b1, 1'b0, 2'b00, 1'b0, 6'h00);
        check("w nop", 32'(w_o), 32'(d ? w0 : r));
        check("carry nop", 32'(carry_o), 32'(ec));
        // Indirect load: all codes at wrap corners, offset limits, random
        for (i = 0; i < 28; i++) begin
            ps = i[0];
            u  = (i < 8) ? i[2:1] : 2'($random(seed));
            rl = (i >= 8 && i < 12) || (i >= 12 && 1'($random(seed)));
            of = (i == 8) ? 6'h20 : (i == 9) ? 6'h1f : 6'($random(seed));
            p  = (i < 8) ? (u[0] ? 16'h0000 : 16'hffff) : 16'($random(seed));
            p2 = 16'($random(seed));
            v  = (i == 2) ? 8'h00 : 8'($random(seed));
            c0 = 1'($random(seed));
            ea = ild_addr(p, u, rl, of);
            np = ild_ptr(p, u, rl);
            wr(ps ? SME_REG_PTR1 : SME_REG_PTR0, {16'h0000, p});
            wr(ps ? SME_REG_PTR0 : SME_REG_PTR1, {16'h0000, p2});
            // Pointed and effective places differ for pre codes and nonzero offsets, so pre/post show apart
            mem_put(p, ~v);
            mem_put(ea, v);
            wr(SME_REG_STAT, {31'h0, c0});
            run_ins(SME_OP_ILOAD, 7'($random(seed)), 1'($random(seed)), ps,
                    u, rl, of);
            check("w load", 32'(w_o), 32'(v));
            check("zero load", 32'(zero_o), 32'(v == 8'h00));
            check("carry load", 32'(carry_o), 32'(c0));
            rd(ps ? SME_REG_PTR1 : SME_REG_PTR0, q);
            check("ptr after", q, {16'h0000, np});
            rd(ps ? SME_REG_PTR0 : SME_REG_PTR1, q);
            check("other ptr", q, {16'h0000, p2});
        end
        end_sim();
    end

endmodule : sme_exec_tb
